// ===== hw/cbdm_bank_div.v
// Purpose: Four bank dividers on one shared source counter, with output gating.
// Assumes: src_tick is a one-cycle pulse per rising source edge.
// Notes: Sharing one counter keeps every bank edge on a common source edge.
`timescale 1ns/1ns
`include "cbdm_regs.vh"

module cbdm_bank_div #(
  parameter C_OUTS = 2,
  parameter D_OUTS = 5
) (
  mclk,
  rst_n,
  src_tick,
  div_sel,
  out_en,
  bank_a_clock_out,
  bank_b_clock_out,
  bank_c_clock_outs,
  bank_d_clock_outs
);
  input  wire              mclk;
  input  wire              rst_n;
  input  wire              src_tick;
  input  wire [3:0]        div_sel;
  input  wire              out_en;
  output reg               bank_a_clock_out;
  output reg               bank_b_clock_out;
  output reg  [C_OUTS-1:0] bank_c_clock_outs;
  output reg  [D_OUTS-1:0] bank_d_clock_outs;

  reg  [`CBDM_DIV_W-1:0] src_cnt;
  wire [3:0]             bank_level;

  // ==========================================
  // Shared source counter
  // R13 one shared source
  // R4 edge driven, no rate floor
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_cnt <= 3'h0;
    end else if (src_tick) begin
      src_cnt <= src_cnt + 3'h1;
    end
  end

  // ==========================================
  // Per-bank tap selection
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bank
      localparam integer LOW = (b == 0) ? `CBDM_TAP_A_LOW : `CBDM_TAP_BCD_LOW;
      // R8 bank A ratios
      // R9 banks B to D ratios
      assign bank_level[b] = div_sel[b] ? src_cnt[LOW+1] : src_cnt[LOW];
    end
  endgenerate

  // ==========================================
  // Output stage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_a_clock_out  <= 1'b0;
      bank_b_clock_out  <= 1'b0;
      bank_c_clock_outs <= {C_OUTS{1'b0}};
      bank_d_clock_outs <= {D_OUTS{1'b0}};
    end else begin
      // R5 output gating
      // R11 bank fanout
      bank_a_clock_out  <= out_en & bank_level[0];
      bank_b_clock_out  <= out_en & bank_level[1];
      bank_c_clock_outs <= {C_OUTS{out_en & bank_level[2]}};
      bank_d_clock_outs <= {D_OUTS{out_en & bank_level[3]}};
    end
  end
endmodule // cbdm_bank_div

// ===== hw/cbdm_osc.v
// Purpose: Digital model of the loop oscillator, a period counter emitting one tick per cycle.
// Assumes: The period steers by one mclk per correction pulse; force_min wins over both steps.
// Notes: Period bounds set the oscillator range; a larger period is a lower frequency.
`timescale 1ns/1ns
`include "cbdm_regs.vh"

module cbdm_osc #(
  parameter [`CBDM_PER_W-1:0] MIN_PER = `CBDM_OSC_MIN_PER,
  parameter [`CBDM_PER_W-1:0] MAX_PER = `CBDM_OSC_MAX_PER
) (
  mclk,
  rst_n,
  force_min,
  speed_up,
  slow_down,
  tick,
  period
);
  input  wire                   mclk;
  input  wire                   rst_n;
  input  wire                   force_min;
  input  wire                   speed_up;
  input  wire                   slow_down;
  output reg                    tick;
  output reg [`CBDM_PER_W-1:0]  period;

  localparam [`CBDM_PER_W-1:0] ONE = 16'h0001;

  reg [`CBDM_PER_W-1:0] cnt;

  // ==========================================
  // Frequency steering
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      period <= `CBDM_OSC_MAX_PER;
    end else if (force_min) begin
      // R6 minimum frequency
      period <= MAX_PER;
    end else if (speed_up && period > MIN_PER) begin
      period <= period - ONE;
    end else if (slow_down && period < MAX_PER) begin
      period <= period + ONE;
    end
  end

  // ==========================================
  // Tick generation
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt >= period - ONE) begin
      cnt  <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + ONE;
      tick <= 1'b0;
    end
  end
endmodule // cbdm_osc

// ===== hw/cbdm_regs.vh
// Purpose: Constants of the clock bank divider and mux block: register map, field positions, loop figures.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per aligned word.
// Notes on behaviour
// R1: The reference select picks the differential reference when low and the single-ended one when high.
// R2: With the loop inactive the chosen reference bypasses the oscillator and feeds the bank dividers.
// R3: With the loop active the bank dividers are fed from the locked oscillator.
// R4: In test mode the divider path is fully static and works at any reference rate down to zero.
// R5: All clock outputs are enabled while output-off is low and disabled while it is high.
// R6: While outputs are disabled the oscillator is forced to its minimum frequency.
// R7: Disabling outputs in loop mode loses lock, and re-enabling them lets the loop relock.
// R8: Bank A gives the source divided by two when its select is low and by four when high.
// R9: Banks B, C and D each give the source divided by four when low and by eight when high.
// R10: The oscillator runs at two, four or eight times the reference, set by the fed-back bank ratio.
// R11: Bank A and B drive one output, C two and D five, all outputs of a bank at one frequency.
// R12: The board wires one bank output to the feedback input and keeps the oscillator in range.
// R13: All banks divide one shared source so outputs of different banks stay phase aligned.
`ifndef CBDM_REGS_VH
`define CBDM_REGS_VH

// ==========================================
// Register map
`define CBDM_OFS_CTRL        4'h0
`define CBDM_OFS_STATUS      4'h4
`define CBDM_OFS_PERIOD      4'h8
`define CBDM_OFS_REF_PERIOD  4'hC
`define CBDM_RD_ZERO         32'h0000_0000

// ==========================================
// Control fields
`define CBDM_CTRL_W          7
`define CBDM_CTRL_RESET      7'h02
`define CBDM_CTRL_REF_SEL    0
`define CBDM_CTRL_LOOP_ON    1
`define CBDM_CTRL_OUT_OFF    2
`define CBDM_CTRL_FSEL_LO    3
`define CBDM_CTRL_FSEL_HI    6

// ==========================================
// Status fields
`define CBDM_STAT_LOCKED     0
`define CBDM_STAT_TEST       1
`define CBDM_STAT_OUT_ON     2
`define CBDM_STAT_REF_SEL    3

// ==========================================
// Divider taps: tap bit n of the source counter is the source divided by 2^(n+1)
`define CBDM_DIV_W           3
`define CBDM_TAP_A_LOW       0
`define CBDM_TAP_BCD_LOW     1

// ==========================================
// Oscillator and loop figures: periods and tolerance in mclk cycles, widths in bits, lock count in reference edges
`define CBDM_PER_W           16
`define CBDM_OSC_MIN_PER     16'h0004
`define CBDM_OSC_MAX_PER     16'h0100
`define CBDM_LOOP_TOL        16'h0001
`define CBDM_LOCK_W          4
`define CBDM_LOCK_COUNT      4'h8

`endif

// ===== hw/cbdm_top.v
// Purpose: Clock bank divider and mux: reference select, loop model, bank dividers, Avalon-MM control.
// Assumes: Clock-like inputs are synchronous samples at mclk; one bank output is wired to loop_feedback_in.
// Notes: Bus answers with waitrequest low in the cycle after a request is first seen.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "cbdm_regs.vh"

module cbdm_top #(
  parameter C_OUTS = 2,
  parameter D_OUTS = 5
) (
  mclk,
  nrst,
  address,
  read,
  write,
  writedata,
  byteenable,
  readdata,
  waitrequest,
  diff_ref_clock_p,
  diff_ref_clock_n,
  single_ended_ref_clock,
  loop_feedback_in,
  bank_a_clock_out,
  bank_b_clock_out,
  bank_c_clock_outs,
  bank_d_clock_outs
);
  input  wire              mclk;
  input  wire              nrst;
  input  wire [3:0]        address;
  input  wire              read;
  input  wire              write;
  input  wire [31:0]       writedata;
  input  wire [3:0]        byteenable;
  output reg  [31:0]       readdata;
  output reg               waitrequest;
  input  wire              diff_ref_clock_p;
  input  wire              diff_ref_clock_n;
  input  wire              single_ended_ref_clock;
  input  wire              loop_feedback_in;
  output wire              bank_a_clock_out;
  output wire              bank_b_clock_out;
  output wire [C_OUTS-1:0] bank_c_clock_outs;
  output wire [D_OUTS-1:0] bank_d_clock_outs;

  localparam [`CBDM_PER_W-1:0] PER_ONE = 16'h0001;
  localparam [`CBDM_PER_W-1:0] PER_SAT = 16'hFFFF;

  // ==========================================
  // Reset release
  reg rst_meta;
  reg rst_n;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================
  // Control register and decoded controls
  reg  [`CBDM_CTRL_W-1:0] ctrl;
  wire                    ref_sel  = ctrl[`CBDM_CTRL_REF_SEL];
  wire                    loop_on  = ctrl[`CBDM_CTRL_LOOP_ON];
  wire                    out_off  = ctrl[`CBDM_CTRL_OUT_OFF];
  wire [3:0]              div_sel  = ctrl[`CBDM_CTRL_FSEL_HI:`CBDM_CTRL_FSEL_LO];

  // ==========================================
  // Reference select and edge detection
  reg  ref_d;
  reg  fb_d;
  wire diff_level = diff_ref_clock_p & ~diff_ref_clock_n;
  // R1 reference select
  wire ref_level  = ref_sel ? single_ended_ref_clock : diff_level;
  wire ref_edge   = ref_level & ~ref_d;
  wire fb_edge    = loop_feedback_in & ~fb_d;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d <= 1'b0;
      fb_d  <= 1'b0;
    end else begin
      ref_d <= ref_level;
      fb_d  <= loop_feedback_in;
    end
  end

  // ==========================================
  // Period measurement of reference and feedback
  reg [`CBDM_PER_W-1:0] ref_cnt;
  reg [`CBDM_PER_W-1:0] fb_cnt;
  reg [`CBDM_PER_W-1:0] ref_per;
  reg [`CBDM_PER_W-1:0] fb_per;
  reg                   fb_valid;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= 16'h0000;
      ref_per <= 16'h0000;
    end else if (ref_edge) begin
      ref_per <= ref_cnt + PER_ONE;
      ref_cnt <= 16'h0000;
    end else if (ref_cnt != PER_SAT) begin
      ref_cnt <= ref_cnt + PER_ONE;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fb_cnt   <= 16'h0000;
      fb_per   <= 16'h0000;
      fb_valid <= 1'b0;
    end else if (out_off) begin
      // R7 loop open, feedback stale
      fb_cnt   <= 16'h0000;
      fb_valid <= 1'b0;
    end else if (fb_edge) begin
      fb_per   <= fb_cnt + PER_ONE;
      fb_cnt   <= 16'h0000;
      fb_valid <= 1'b1;
    end else if (fb_cnt != PER_SAT) begin
      fb_cnt <= fb_cnt + PER_ONE;
    end else begin
      // A silent feedback input means the loop has no feedback
      fb_valid <= 1'b0;
    end
  end

  // ==========================================
  // Frequency compare and lock detection
  reg                    speed_up;
  reg                    slow_down;
  reg                    locked;
  reg [`CBDM_LOCK_W-1:0] match_cnt;
  reg [1:0]              fb_fresh;
  wire                   loop_run  = loop_on & ~out_off & fb_valid;
  wire                   fb_slow   = fb_per > ref_per + `CBDM_LOOP_TOL;
  wire                   fb_fast   = fb_per + `CBDM_LOOP_TOL < ref_per;
  wire [`CBDM_PER_W:0]   ref_twice = {ref_per, 1'b0};
  wire                   fb_far    = {1'b0, fb_per} > ref_twice;
  // Near lock a step waits for a feedback period measured wholly after the last step;
  // a stale reading would push the period past the lock point and make the loop hunt
  wire                   step_ok   = fb_far | fb_fresh[1];
  wire                   step_now  = loop_run & ref_edge & step_ok & (fb_slow | fb_fast);

  // Feedback edges seen since the last period step, saturating at two
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fb_fresh <= 2'h0;
    end else if (step_now) begin
      fb_fresh <= 2'h0;
    end else if (fb_edge && !fb_fresh[1]) begin
      fb_fresh <= fb_fresh + 2'h1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speed_up  <= 1'b0;
      slow_down <= 1'b0;
      locked    <= 1'b0;
      match_cnt <= 4'h0;
    end else if (!loop_run) begin
      // R7 lock lost without feedback
      speed_up  <= 1'b0;
      slow_down <= 1'b0;
      locked    <= 1'b0;
      match_cnt <= 4'h0;
    end else if (ref_edge) begin
      // R10 oscillator tracks ratio
      speed_up  <= fb_slow & step_ok;
      slow_down <= fb_fast & step_ok;
      if (fb_slow || fb_fast) begin
        locked    <= 1'b0;
        match_cnt <= 4'h0;
      end else if (match_cnt == `CBDM_LOCK_COUNT) begin
        // R7 loop recovers
        locked <= 1'b1;
      end else begin
        match_cnt <= match_cnt + 4'h1;
      end
    end else begin
      speed_up  <= 1'b0;
      slow_down <= 1'b0;
    end
  end

  // ==========================================
  // Oscillator
  wire                   osc_tick;
  wire [`CBDM_PER_W-1:0] osc_period;

  // R6 forced slow while outputs off
  cbdm_osc u_osc (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .force_min (out_off),
    .speed_up  (speed_up),
    .slow_down (slow_down),
    .tick      (osc_tick),
    .period    (osc_period)
  );

  // ==========================================
  // Source mux into the bank dividers
  // R2 test mode bypass
  // R3 oscillator feeds dividers
  wire src_tick = loop_on ? osc_tick : ref_edge;

  cbdm_bank_div #(
    .C_OUTS (C_OUTS),
    .D_OUTS (D_OUTS)
  ) u_div (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .src_tick          (src_tick),
    .div_sel           (div_sel),
    .out_en            (~out_off),
    .bank_a_clock_out  (bank_a_clock_out),
    .bank_b_clock_out  (bank_b_clock_out),
    .bank_c_clock_outs (bank_c_clock_outs),
    .bank_d_clock_outs (bank_d_clock_outs)
  );

  // ==========================================
  // Avalon-MM slave
  // A request is seen with waitrequest high, answered one cycle later with waitrequest low,
  // and completed on the edge that samples it low; a request still held then sees one cycle of waitrequest high and is answered again.
  wire req    = read | write;
  wire finish = req & ~waitrequest;
  reg  [31:0] next_readdata;

  always @* begin
    next_readdata = `CBDM_RD_ZERO;
    case (address)
      `CBDM_OFS_CTRL: begin
        next_readdata[`CBDM_CTRL_W-1:0] = ctrl;
      end
      `CBDM_OFS_STATUS: begin
        next_readdata[`CBDM_STAT_LOCKED]  = locked;
        next_readdata[`CBDM_STAT_TEST]    = ~loop_on;
        next_readdata[`CBDM_STAT_OUT_ON]  = ~out_off;
        next_readdata[`CBDM_STAT_REF_SEL] = ref_sel;
      end
      `CBDM_OFS_PERIOD: begin
        next_readdata[`CBDM_PER_W-1:0] = osc_period;
      end
      `CBDM_OFS_REF_PERIOD: begin
        next_readdata[`CBDM_PER_W-1:0] = ref_per;
      end
      default: begin
        next_readdata = `CBDM_RD_ZERO;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= `CBDM_RD_ZERO;
    end else if (req && waitrequest) begin
      waitrequest <= 1'b0;
      if (read) begin
        readdata <= next_readdata;
      end
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CBDM_CTRL_RESET;
    end else if (finish && write && address == `CBDM_OFS_CTRL && byteenable[0]) begin
      // R5 software output-off control
      ctrl <= writedata[`CBDM_CTRL_W-1:0];
    end
  end
endmodule // cbdm_top

// ===== tb/cbdm_checker.sv
// Purpose: Port checks on the clock bank top.
// Assumes: Master holds a request until waitrequest low.
// Notes: A copy of the control word follows accepted writes.
`timescale 1ns/1ns

module cbdm_checker #(
  parameter C_OUTS = 2,
  parameter D_OUTS = 5
) (
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic [3:0]        address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic [3:0]        byteenable,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  input wire logic              diff_ref_clock_p,
  input wire logic              diff_ref_clock_n,
  input wire logic              single_ended_ref_clock,
  input wire logic              loop_feedback_in,
  input wire logic              bank_a_clock_out,
  input wire logic              bank_b_clock_out,
  input wire logic [C_OUTS-1:0] bank_c_clock_outs,
  input wire logic [D_OUTS-1:0] bank_d_clock_outs
);
  // ========
  // Control copy
  logic [6:0] ctrl;
  wire        quiet = !(bank_a_clock_out | bank_b_clock_out | (|bank_c_clock_outs) | (|bank_d_clock_outs));
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      ctrl <= 7'h02;
    else if (write && !waitrequest && address == 4'h0 && byteenable[0])
      ctrl <= writedata[6:0];

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence s_off_wr;
    write && !waitrequest && address == 4'h0 && byteenable[0] && writedata[2];
  endsequence
  // Test mode, control and every reference line idle
  sequence s_still;
    (!ctrl[1] && !ctrl[2] && $stable(ctrl) && $stable({diff_ref_clock_p, diff_ref_clock_n, single_ended_ref_clock}))[*6];
  endsequence

  // ========
  // Assertions
  a_bus_answer: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("no bus answer");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  a_wait_idle: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  a_c_equal: assert property (bank_c_clock_outs == {C_OUTS{bank_c_clock_outs[0]}})
    else $error("bank c split");
  a_d_equal: assert property (bank_d_clock_outs == {D_OUTS{bank_d_clock_outs[0]}})
    else $error("bank d split");
  a_out_gated: assert property (s_off_wr |-> ##2 quiet [*2])
    else $error("outputs not off");
  a_status_mirror: assert property (read && !waitrequest && address == 4'h4 |-> readdata[3:1] == {ctrl[0], !ctrl[2], !ctrl[1]})
    else $error("status wrong");
  a_period_min: assert property (ctrl[2] && read && !waitrequest && address == 4'h8 |-> readdata[15:0] == 16'h0100)
    else $error("period not min");
  a_test_frozen: assert property (s_still |-> $stable({bank_a_clock_out, bank_b_clock_out, bank_d_clock_outs}))
    else $error("outputs move");
endmodule // cbdm_checker

bind cbdm_top cbdm_checker #(.C_OUTS(C_OUTS), .D_OUTS(D_OUTS)) cbdm_checker_i (
  .mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .diff_ref_clock_p(diff_ref_clock_p),
  .diff_ref_clock_n(diff_ref_clock_n), .single_ended_ref_clock(single_ended_ref_clock),
  .loop_feedback_in(loop_feedback_in), .bank_a_clock_out(bank_a_clock_out),
  .bank_b_clock_out(bank_b_clock_out), .bank_c_clock_outs(bank_c_clock_outs),
  .bank_d_clock_outs(bank_d_clock_outs)
);

// ===== tb/cbdm_ref_src.sv
// Purpose: Reference source and board feedback wire.
// Assumes: Bench asks for bursts of whole periods.
// Notes: Between bursts diff_p and se_ref rest low and diff_n rests high, as a stopped source.
`timescale 1ns/1ns

module cbdm_ref_src (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [15:0] npulse,
  input  wire logic [15:0] half,
  input  wire logic [1:0]  line_sel,
  input  wire logic        fb_src,
  output wire logic        diff_p,
  output wire logic        diff_n,
  output wire logic        se_ref,
  output logic             fb_out,
  output wire logic        busy
);
  int   cnt = 0;
  int   left = 0;
  logic lvl = 1'b0;

  // ========
  // Bursts
  always @(posedge mclk) begin
    if (go) begin
      left <= 2 * npulse;
      cnt <= 0;
    end else if (left > 0) begin
      if (cnt == half - 1) begin
        cnt <= 0;
        lvl <= ~lvl;
        left <= left - 1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  assign busy = go || left > 0;
  assign diff_p = line_sel[0] & lvl;
  assign diff_n = ~diff_p;
  assign se_ref = line_sel[1] & lvl;

  // ========
  // Feedback
  initial fb_out = 1'b0;
  always @(posedge mclk)
    fb_out <= fb_src;
endmodule // cbdm_ref_src

// ===== tb/test_clock_bank_divider_mux.sv
// Purpose: Self-checking bench of the clock bank top.
// Assumes: Bank A is wired back as loop feedback.
// Notes: Toggle counts over whole bursts need no phase.
`timescale 1ns/1ns

module test_clock_bank_divider_mux;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'h03b2_adef;
  logic [1:0]  line_sel = 2'h0;
  logic [15:0] npulse = 16'h0000;
  logic [15:0] half = 16'h0004;
  logic [3:0]  q_d = 4'h0;
  int          tg[4] = '{0, 0, 0, 0};
  int          base[4];
  int          n_fail = 0;
  int          samples_checked = 0;
  wire [31:0]  readdata;
  wire         waitrequest, dp, dn, se, fb, busy, bank_a, bank_b;
  wire [1:0]   bank_c;
  wire [4:0]   bank_d;
  wire [3:0]   q = {bank_d[0], bank_c[0], bank_b, bank_a};

  cbdm_top cbdm_top_i (
    .mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .diff_ref_clock_p(dp), .diff_ref_clock_n(dn),
    .single_ended_ref_clock(se), .loop_feedback_in(fb), .bank_a_clock_out(bank_a),
    .bank_b_clock_out(bank_b), .bank_c_clock_outs(bank_c), .bank_d_clock_outs(bank_d)
  );
  cbdm_ref_src cbdm_ref_src_i (
    .mclk(mclk), .go(go), .npulse(npulse), .half(half), .line_sel(line_sel),
    .fb_src(bank_a), .diff_p(dp), .diff_n(dn), .se_ref(se), .fb_out(fb), .busy(busy)
  );

  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++)
      if (q[i] !== q_d[i])
        tg[i] = tg[i] + 1;
    q_d = q;
  end

  // ========
  // Tasks
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge mclk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      check(32'h0000_0000, 32'h0000_0001);
      summarize();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic burst(input int n, input logic [1:0] ls);
    int k;
    k = 0;
    for (int i = 0; i < 4; i++)
      base[i] = tg[i];
    npulse <= n[15:0];
    line_sel <= ls;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    do begin
      @(posedge mclk);
      k++;
    end while (busy === 1'b1 && k < 20000);
    if (k >= 20000) begin
      check(32'h0000_0000, 32'h0000_0001);
      summarize();
    end
    repeat (8) @(posedge mclk);
  endtask

  // ========
  // Main sequence
  initial begin
    logic [31:0] c;
    int          s;
    int          b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_0002);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(rd[3:1], 3'b010);
    bus(1'b1, 4'h4, 32'hffff_ffff);
    byteenable <= 4'he;
    bus(1'b1, 4'h0, 32'h0000_007d);
    byteenable <= 4'hf;
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_0002);
    bus(1'b0, 4'h6, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    for (int it = 0; it < 6; it++) begin
      lfsr = step(lfsr);
      c = {25'h0, it == 0 ? 4'h0 : it == 4 ? 4'hf : lfsr[6:3], it == 2, 1'b0, it[0]};
      half <= it == 5 ? 16'h0028 : 16'h0004;
      bus(1'b1, 4'h0, c);
      repeat (4) @(posedge mclk);
      burst(16, c[0] ? 2'b01 : 2'b10);
      for (int i = 0; i < 4; i++)
        check(tg[i] - base[i], 32'h0000_0000);
      burst(16, c[0] ? 2'b10 : 2'b01);
      for (int i = 0; i < 4; i++) begin
        s = c[3 + i];
        check(tg[i] - base[i], c[2] ? 0 : 32 / (i == 0 ? (s ? 4 : 2) : (s ? 8 : 4)));
      end
      if (c[2]) begin
        bus(1'b0, 4'h8, 32'h0000_0000);
        check(rd, 32'h0000_0100);
        check(q, 4'h0);
      end
    end
    half <= 16'h0008;
    bus(1'b1, 4'h0, 32'h0000_0002);
    burst(400, 2'b01);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(rd[2:0], 3'b101);
    bus(1'b0, 4'h8, 32'h0000_0000);
    check(rd, 32'h0000_0008);
    bus(1'b0, 4'hc, 32'h0000_0000);
    check(rd, 32'h0000_0010);
    b0 = tg[0];
    repeat (64) @(posedge mclk);
    check(tg[0] - b0 >= 7 && tg[0] - b0 <= 9, 1'b1);
    bus(1'b1, 4'h0, 32'h0000_0006);
    burst(16, 2'b01);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(rd[2:0], 3'b000);
    bus(1'b0, 4'h8, 32'h0000_0000);
    check(rd, 32'h0000_0100);
    bus(1'b1, 4'h0, 32'h0000_0002);
    burst(400, 2'b01);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(rd[2:0], 3'b101);
    summarize();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    check(32'h0000_0000, 32'h0000_0001);
    summarize();
  end
endmodule // test_clock_bank_divider_mux
